// ===== design/sslc_pkg.sv
// Shared constants and word layouts for the synthesizer serial load block.
package sslc_pkg;

  localparam int WORD_W = 19;
  localparam int SEL_POS = 0;
  localparam logic SEL_REF = 1'h1;
  localparam int SYNC_STAGES = 2;

  // Reference word: operating bits sit ahead of the divider value.
  localparam int SPARE_POS = 18;
  localparam int CPUMP_POS = 17;
  localparam int LOCKSEL_POS = 16;
  localparam int PHASE_POS = 15;
  localparam int REFDIV_LSB = 1;
  localparam int REFDIV_W = 14;
  localparam int MAINDIV_LSB = 8;
  localparam int MAINDIV_W = 11;
  localparam int SWALLOW_LSB = 1;
  localparam int SWALLOW_W = 7;

  typedef struct packed {
    logic spareBit;
    logic chargePumpHigh;
    logic lock_output_select;
    logic phase_polarity_bit;
    logic [13:0] refDivider;
    logic latch_select_bit;
  } sslc_ref_t;

  typedef struct packed {
    logic [10:0] mainDivider;
    logic [6:0] swallowCount;
    logic latch_select_bit;
  } sslc_main_t;

  localparam logic [18:0] REF_RST = 19'h00000;
  localparam logic [18:0] MAIN_RST = 19'h00000;

endpackage : sslc_pkg

// ===== design/sslc_sync.sv
// Two-stage level synchroniser, one chain per bit.
`timescale 1ns/10ps
module sslc_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] stable_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_stable;

  genvar g;
  generate
    for (g = 0; g < W; g++) begin : gBit
      always_comb begin
        nxt_meta[g] = resetn ? asyncIn[g] : 1'h0;
        nxt_stable[g] = resetn ? meta_ff[g] : 1'h0;
      end
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    meta_ff <= nxt_meta;
    stable_ff <= nxt_stable;
  end

  assign syncOut = stable_ff;

endmodule : sslc_sync

// ===== design/sslc_loader.sv
// Serial divider-word loader: shift on the host clock, latch on the core clock.
`timescale 1ns/10ps
module sslc_loader (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic shiftClk,
  input wire logic serialData,
  input wire logic load_strobe,
  input wire logic lockRaw,
  input wire logic freqMonRaw,
  output sslc_pkg::sslc_ref_t refLatch,
  output sslc_pkg::sslc_main_t mainLatch,
  output logic refLoaded,
  output logic mainLoaded,
  output logic loadDone,
  output logic lock_indicator
);

  // Link domain: the shift register runs on the host's shift clock.
  // It carries no reset because that clock stands still outside a word.
  // A word shorter than 19 bits leaves stale upper bits, which the latch then copies.
  logic [sslc_pkg::WORD_W-1:0] shift_ff;
  logic [sslc_pkg::WORD_W-1:0] nxt_shift;

  always_comb begin
    nxt_shift = {shift_ff[sslc_pkg::WORD_W-2:0], serialData};
  end

  always_ff @(posedge shiftClk) begin
    shift_ff <= nxt_shift;
  end

  // Core domain: strobe and monitor inputs arrive from pins.
  // The strobe shares the two-stage chain with the monitor pins. This costs two
  // core cycles of load latency but keeps metastability off the latch enables.
  logic [2:0] pinSync;

  sslc_sync #(
    .W(3)
  ) uPinSync (
    .core_clk(core_clk),
    .resetn(resetn),
    .asyncIn({load_strobe, lockRaw, freqMonRaw}),
    .syncOut(pinSync)
  );

  logic strobeSync;
  logic lockSync;
  logic freqSync;
  assign strobeSync = pinSync[2];
  assign lockSync = pinSync[1];
  assign freqSync = pinSync[0];

  logic strobeDly_ff;
  sslc_pkg::sslc_ref_t ref_ff;
  sslc_pkg::sslc_main_t main_ff;
  logic refLoaded_ff;
  logic mainLoaded_ff;
  logic loadDone_ff;
  logic monitor_ff;

  logic nxt_strobeDly;
  sslc_pkg::sslc_ref_t nxt_ref;
  sslc_pkg::sslc_main_t nxt_main;
  logic nxt_refLoaded;
  logic nxt_mainLoaded;
  logic nxt_loadDone;
  logic nxt_monitor;
  logic strobeRise;
  logic toRef;

  // The host holds the shift clock still while the strobe is high, so the
  // word is quiet when the synchronised strobe edge samples it here.
  always_comb begin
    strobeRise = strobeSync & ~strobeDly_ff;
    toRef = (shift_ff[sslc_pkg::SEL_POS] == sslc_pkg::SEL_REF);
    nxt_strobeDly = strobeSync;
    nxt_ref = ref_ff;
    nxt_main = main_ff;
    nxt_refLoaded = refLoaded_ff;
    nxt_mainLoaded = mainLoaded_ff;
    nxt_loadDone = 1'h0;
    if (strobeRise) begin
      nxt_loadDone = 1'h1;
      if (toRef) begin
        nxt_ref = sslc_pkg::sslc_ref_t'(shift_ff);
        nxt_refLoaded = 1'h1;
      end else begin
        nxt_main = sslc_pkg::sslc_main_t'(shift_ff);
        nxt_mainLoaded = 1'h1;
      end
    end
    // A divided-frequency monitor replaces lock when the select bit is set.
    nxt_monitor = ref_ff.lock_output_select ? freqSync : lockSync;
    if (!resetn) begin
      nxt_strobeDly = 1'h0;
      nxt_ref = sslc_pkg::sslc_ref_t'(sslc_pkg::REF_RST);
      nxt_main = sslc_pkg::sslc_main_t'(sslc_pkg::MAIN_RST);
      nxt_refLoaded = 1'h0;
      nxt_mainLoaded = 1'h0;
      nxt_loadDone = 1'h0;
      nxt_monitor = 1'h0;
    end
  end

  always_ff @(posedge core_clk) begin
    strobeDly_ff <= nxt_strobeDly;
    ref_ff <= nxt_ref;
    main_ff <= nxt_main;
    refLoaded_ff <= nxt_refLoaded;
    mainLoaded_ff <= nxt_mainLoaded;
    loadDone_ff <= nxt_loadDone;
    monitor_ff <= nxt_monitor;
  end

  assign refLatch = ref_ff;
  assign mainLatch = main_ff;
  assign refLoaded = refLoaded_ff;
  assign mainLoaded = mainLoaded_ff;
  assign loadDone = loadDone_ff;
  assign lock_indicator = monitor_ff;

  // Checks on the link domain.
  // Case equality lets the unreset upper bits match while the first word fills them.
  shift_capture_a: assert property (@(posedge shiftClk)
    1'b1 ##1 ((shift_ff[sslc_pkg::WORD_W-1:1] === $past(shift_ff[sslc_pkg::WORD_W-2:0]))
      && (shift_ff[0] == $past(serialData))))
    else $error("shift register did not take one bit per edge");

  // Checks on the core domain.
  ref_dest_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (strobeRise && toRef) |=> (ref_ff == sslc_pkg::sslc_ref_t'($past(shift_ff)))
      && $stable(main_ff))
    else $error("reference word went to the wrong latch");

  main_dest_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (strobeRise && !toRef) |=> (main_ff == sslc_pkg::sslc_main_t'($past(shift_ff)))
      && $stable(ref_ff))
    else $error("main word went to the wrong latch");

  load_on_edge_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(load_strobe) |-> ##[3:4] loadDone)
    else $error("strobe rise gave no load within four cycles");

  latch_hold_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !strobeRise |=> $stable(ref_ff) && $stable(main_ff) && !loadDone)
    else $error("latch changed without a strobe edge");

  either_order_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (strobeRise && !toRef && !refLoaded_ff) |=> mainLoaded && !refLoaded)
    else $error("main word refused before reference word");

  done_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
    loadDone |=> !loadDone)
    else $error("load done pulse lasted more than one cycle");

  ref_sticky_a: assert property (@(posedge core_clk) disable iff (!resetn)
    refLoaded |=> refLoaded)
    else $error("reference loaded flag dropped without reset");

  main_sticky_a: assert property (@(posedge core_clk) disable iff (!resetn)
    mainLoaded |=> mainLoaded)
    else $error("main loaded flag dropped without reset");

  lock_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !ref_ff.lock_output_select |=> (lock_indicator == $past(lockSync)))
    else $error("monitor output did not follow the lock pin");

  freq_follow_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ref_ff.lock_output_select |=> (lock_indicator == $past(freqSync)))
    else $error("monitor output did not follow the frequency pin");

  // The chain is only full two edges after reset has been released.
  pin_sync_a: assert property (@(posedge core_clk) disable iff (!resetn)
    ($past(resetn) && $past(resetn, 2)) |-> (lockSync == $past(lockRaw, 2)))
    else $error("lock pin did not pass two flip-flops");

  // Reset clears every output by the edge after it is sampled low.
  reset_clear_a: assert property (@(posedge core_clk)
    !resetn |=> !refLoaded && !mainLoaded && !loadDone && !lock_indicator
      && (ref_ff == sslc_pkg::sslc_ref_t'(sslc_pkg::REF_RST))
      && (main_ff == sslc_pkg::sslc_main_t'(sslc_pkg::MAIN_RST)))
    else $error("reset left an output set");

  refFirstC: cover property (@(posedge core_clk) disable iff (!resetn)
    strobeRise && toRef && !mainLoaded_ff);
  mainFirstC: cover property (@(posedge core_clk) disable iff (!resetn)
    strobeRise && !toRef && !refLoaded_ff);
  bothLoadedC: cover property (@(posedge core_clk) disable iff (!resetn)
    refLoaded && mainLoaded && lock_indicator);
  monitorSelC: cover property (@(posedge core_clk) disable iff (!resetn)
    ref_ff.lock_output_select && lock_indicator);

endmodule : sslc_loader

// ===== bench/sslc_host.sv
// Host model that shifts divider words into the loader and strobes them.
`timescale 1ns/10ps
module sslc_host (
  output logic shiftClk,
  output logic serialData,
  output logic load_strobe
);
  // Radio-side pins of the host, which the loader itself does not have.
  logic supplyOn;
  logic receive_select_n;
  logic transmit_select_n;
  initial begin
    shiftClk = 1'h0;
    serialData = 1'h0;
    load_strobe = 1'h0;
    supplyOn = 1'h0;
    receive_select_n = 1'h1;
    transmit_select_n = 1'h1;
    #1 supplyOn = 1'h1;
  end
  // The 5 to 40 ms waits and the preamble gate data.
  // Those waits outlast this run and no radio data is modelled, so they are not timed here.
  // whole word first
  task automatic sendWord(input logic [18:0] w);
    transmit_select_n = 1'h1;
    receive_select_n = 1'h0;
    // A small offset keeps the link edges off the core clock edges.
    #3;
    if (supplyOn) begin
      for (int i = 18; i >= 0; i--) begin
        serialData = w[i];
        #80 shiftClk = 1'h1;
        #80 shiftClk = 1'h0;
      end
      // The released line shows the inverse so a stale bit cannot pass for data.
      serialData = ~w[0];
      #40 load_strobe = 1'h1;
      #80 load_strobe = 1'h0;
    end
    #77;
  endtask : sendWord
endmodule : sslc_host

// ===== bench/test_synth_serial_load_channel_seq.sv
// Self-checking bench for the serial divider-word loader.
`timescale 1ns/10ps
module test_synth_serial_load_channel_seq;
  logic core_clk;
  logic resetn;
  logic shiftClk;
  logic serialData;
  logic load_strobe;
  logic lockRaw;
  logic freqMonRaw;
  sslc_pkg::sslc_ref_t refLatch;
  sslc_pkg::sslc_main_t mainLatch;
  logic refLoaded;
  logic mainLoaded;
  logic loadDone;
  logic lock_indicator;
  int badCount = 0;
  int nTests = 0;
  int cycles = 0;
  int k;
  logic [18:0] refExp;
  logic [18:0] mainExp;
  sslc_loader i_dut (.core_clk(core_clk), .resetn(resetn), .shiftClk(shiftClk),
    .serialData(serialData), .load_strobe(load_strobe), .lockRaw(lockRaw),
    .freqMonRaw(freqMonRaw), .refLatch(refLatch), .mainLatch(mainLatch),
    .refLoaded(refLoaded), .mainLoaded(mainLoaded), .loadDone(loadDone),
    .lock_indicator(lock_indicator));
  sslc_host i_host (.shiftClk(shiftClk), .serialData(serialData), .load_strobe(load_strobe));
  initial begin
    core_clk = 1'h0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic testDone();
    if (badCount == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : testDone
  // A full run needs about 4000 cycles.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      badCount++;
      testDone();
    end
  end
  task automatic chkWord(input string s, input logic [18:0] e, input logic [18:0] g);
    nTests++;
    if (g !== e) begin
      badCount++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask : chkWord
  task automatic chkBit(input string s, input logic e, input logic g);
    chkWord(s, {18'h0, e}, {18'h0, g});
  endtask : chkBit
  function automatic logic [18:0] refWord(input logic [13:0] r);
    return {4'h1, r, sslc_pkg::SEL_REF};
  endfunction : refWord
  function automatic logic [18:0] mainWord(input int ch);
    int n;
    n = 34904 + ch;
    return {11'(n / 64), 7'(n % 64), ~sslc_pkg::SEL_REF};
  endfunction : mainWord
  task automatic loadWord(input logic [18:0] w);
    int i;
    fork
      i_host.sendWord(w);
      begin
        // Sample a settled value after each edge; the pulse lasts one cycle only.
        for (i = 0; i < 1000 && loadDone !== 1'h1; i++) begin
          @(posedge core_clk);
          #1;
        end
        chkBit("loadDone", 1'h1, loadDone);
        @(posedge core_clk);
        #1;
        chkBit("loadDone", 1'h0, loadDone);
      end
    join
  endtask : loadWord
  initial begin
    resetn = 1'h0;
    lockRaw = 1'h0;
    freqMonRaw = 1'h0;
    void'($urandom(32'hFFA4));
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) resetn = 1'h1;
    @(negedge core_clk);
    chkBit("refLoaded", 1'h0, refLoaded);
    chkBit("mainLoaded", 1'h0, mainLoaded);
    mainExp = mainWord(0);
    loadWord(mainExp);
    chkWord("mainLatch", mainExp, mainLatch);
    chkBit("refLoaded", 1'h0, refLoaded);
    chkBit("mainLoaded", 1'h1, mainLoaded);
    refExp = refWord(14'h06A4);
    loadWord(refExp);
    chkWord("refLatch", refExp, refLatch);
    chkWord("mainLatch", mainExp, mainLatch);
    chkBit("refLoaded", 1'h1, refLoaded);
    // The first two channels straddle the rollover of the swallow count.
    for (k = 0; k < 8; k++) begin
      mainExp = mainWord(k < 2 ? 39 + k : int'($urandom_range(49)));
      loadWord(mainExp);
      chkWord("mainLatch", mainExp, mainLatch);
      chkWord("refLatch", refExp, refLatch);
    end
    for (k = 0; k < 8; k++) begin
      @(negedge core_clk);
      lockRaw = 1'($urandom);
      freqMonRaw = ~lockRaw;
      repeat (3) @(posedge core_clk);
      #1 chkBit("lock_indicator", lockRaw, lock_indicator);
    end
    // The monitor select is set only to prove the divided-frequency path.
    refExp = refWord(14'h06A4) | 19'h10000;
    loadWord(refExp);
    chkWord("refLatch", refExp, refLatch);
    for (k = 0; k < 4; k++) begin
      @(negedge core_clk);
      lockRaw = 1'($urandom);
      freqMonRaw = ~lockRaw;
      repeat (3) @(posedge core_clk);
      #1 chkBit("lock_indicator", freqMonRaw, lock_indicator);
    end
    @(negedge core_clk) resetn = 1'h0;
    repeat (4) @(negedge core_clk);
    resetn = 1'h1;
    @(negedge core_clk);
    chkWord("refLatch", sslc_pkg::REF_RST, refLatch);
    chkBit("refLoaded", 1'h0, refLoaded);
    chkWord("mainLatch", sslc_pkg::MAIN_RST, mainLatch);
    chkBit("mainLoaded", 1'h0, mainLoaded);
    chkBit("lock_indicator", 1'h0, lock_indicator);
    loadWord(mainExp);
    chkWord("mainLatch", mainExp, mainLatch);
    chkBit("mainLoaded", 1'h1, mainLoaded);
    testDone();
  end
endmodule : test_synth_serial_load_channel_seq
